//--- hw/fpc_debounce.sv
// Button synchroniser and debouncer
`include "fpc_defs.svh"
`default_nettype none
module fpc_debounce #(
	parameter int unsigned DEB_CYC = `FPC_DEB_CYC
) (
	input  wire logic       clk,
	input  wire logic       srst,
	input  wire logic [4:0] btn_n,
	fpc_if.btn              evt
);
	fpc_pkg::fpc_deb_t st;
	fpc_pkg::fpc_deb_t next_st;

	always_comb begin
		next_st = st;
		next_st.s0 = btn_n;
		next_st.s1 = st.s0;
		next_st.press = 5'h0;
		for (int k = 0; k < 5; k++) begin
			// Pins are active low; stable holds the pressed level
			if (st.s1[k] != st.stable[k]) begin
				next_st.cnt[k] = 17'h0;
			end else if (st.cnt[k] == 17'(DEB_CYC - 1)) begin
				next_st.stable[k] = ~st.s1[k];
				next_st.press[k]  = ~st.s1[k];
				next_st.cnt[k]    = 17'h0;
			end else begin
				next_st.cnt[k] = st.cnt[k] + 17'h1;
			end
		end
		if (srst) begin
			next_st    = '0;
			// Synchronisers rest at the released level, so no false press follows
			next_st.s0 = 5'h1f;
			next_st.s1 = 5'h1f;
		end
	end

	always_ff @(posedge clk) begin
		st <= next_st;
	end

	assign evt.press = st.press;
endmodule // fpc_debounce
`default_nettype wire

//--- hw/fpc_quad.sv
// Quadrature decoder for both rotary encoders
`default_nettype none
module fpc_quad (
	input  wire logic       clk,
	input  wire logic       srst,
	input  wire logic [1:0] enc_a,
	input  wire logic [1:0] enc_b,
	fpc_if.enc              evt
);
	fpc_pkg::fpc_quad_t st;
	fpc_pkg::fpc_quad_t next_st;

	always_comb begin
		next_st = st;
		next_st.a0 = enc_a;
		next_st.b0 = enc_b;
		next_st.a1 = st.a0;
		next_st.b1 = st.b0;
		next_st.ap = st.a1;
		next_st.bp = st.b1;
		for (int k = 0; k < 2; k++) begin
			// Double changes are contact noise and are dropped
			next_st.step[k] = (st.a1[k] ^ st.ap[k]) ^ (st.b1[k] ^ st.bp[k]);
			next_st.up[k]   = st.ap[k] ^ st.b1[k];
		end
		// Synchronisers keep sampling in reset so no false step follows it
		if (srst) begin
			next_st.step = 2'h0;
			next_st.up   = 2'h0;
		end
	end

	always_ff @(posedge clk) begin
		st <= next_st;
	end

	assign evt.step = st.step;
	assign evt.up   = st.up;
endmodule // fpc_quad
`default_nettype wire

//--- hw/fpc_top.sv
// Front panel indicator controller with APB register slave
//
// Design decisions made here: the placing of the registers and the APB register port.
`include "fpc_defs.svh"
`default_nettype none
module fpc_top #(
	parameter int unsigned DEB_CYC   = `FPC_DEB_CYC,
	parameter int unsigned FLASH_CYC = `FPC_FLASH_CYC
) (
	input  wire logic                clk,
	input  wire logic                srst,
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [11:0]         paddr,
	input  wire logic [31:0]         pwdata,
	output var  logic [31:0]         prdata,
	output var  logic                pready,
	output var  logic                pslverr,
	input  wire logic                output_toggle_button_n,
	input  wire logic                abort_escape_button_n,
	input  wire logic                local_menu_button_n,
	input  wire logic                venc_push_n,
	input  wire logic                ienc_push_n,
	input  wire logic                venc_a,
	input  wire logic                venc_b,
	input  wire logic                ienc_a,
	input  wire logic                ienc_b,
	input  wire logic                output_active,
	input  wire logic                voltage_regulation,
	input  wire logic                current_regulation,
	input  wire logic                err_pending,
	input  wire logic                err_clearable,
	input  wire logic                analog_control_port,
	input  wire logic                host_remote,
	input  wire logic                link_rx_busy,
	input  wire logic                link_tx_busy,
	output var  logic                gen_enable,
	output var  logic                fault_shutdown_en,
	output var  logic                err_clear,
	output var  logic                local_take,
	output var  logic                led_output_active,
	output var  logic                led_fault_shutdown,
	output var  logic                led_remote,
	output var  logic                led_error,
	output var  logic                led_rx,
	output var  logic                led_tx,
	output var  logic                led_vreg,
	output var  logic                led_ireg,
	output var  logic                led_venc,
	output var  logic                led_ienc,
	output var  fpc_pkg::fpc_disp_t  vdisp_sel,
	output var  fpc_pkg::fpc_disp_t  idisp_sel,
	output var  logic                vdisp_s_mark,
	output var  logic                idisp_s_mark
);
	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		fpc_pkg::fpc_panel_t panel;
		logic                gen_req;
		logic                kill_en;
		logic                err_clear;
		logic                local_take;
		logic                power_sel;
		logic                meas_v;
		logic                meas_i;
		logic [3:0]          menu_pos;
		logic [15:0]         menu_val;
		logic [15:0]         vset;
		logic [15:0]         iset;
		logic [15:0]         vlim;
		logic [15:0]         ilim;
		logic [18:0]         flash_cnt;
		logic                flash_ph;
		logic [3:0]          half_cnt;
		logic                alt_ph;
		logic                rx_seen;
		logic                tx_seen;
		logic [3:0]          vrng;
		logic [3:0]          irng;
		logic [9:0]          led;
		fpc_pkg::fpc_disp_t  vdisp;
		fpc_pkg::fpc_disp_t  idisp;
		logic                vmark;
		logic                imark;
		logic [31:0]         prdata;
		logic                pready;
		logic                pslverr;
	} fpc_core_t;

	fpc_core_t st;
	fpc_core_t next_st;
	fpc_if     evt ();

	// ----------------------------------------
	// Input stages
	// ----------------------------------------
	fpc_debounce #(
		.DEB_CYC (DEB_CYC)
	) u_deb (
		.clk   (clk),
		.srst  (srst),
		.btn_n ({ienc_push_n, venc_push_n, local_menu_button_n,
			abort_escape_button_n, output_toggle_button_n}),
		.evt   (evt.btn)
	);

	fpc_quad u_quad (
		.clk   (clk),
		.srst  (srst),
		.enc_a ({ienc_a, venc_a}),
		.enc_b ({ienc_b, venc_b}),
		.evt   (evt.enc)
	);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Saturating step; the top bit reports a hit on the range end
	function automatic logic [16:0] fpc_step(
		input logic [15:0] val,
		input logic [15:0] lim,
		input logic        up
	);
		if (up) begin
			return (val >= lim) ? {1'b1, lim} : {1'b0, val + 16'h0001};
		end
		return (val == 16'h0000) ? {1'b1, 16'h0000} : {1'b0, val - 16'h0001};
	endfunction

	function automatic logic fpc_cur_item(input logic [3:0] pos);
		logic [15:0] mask;
		mask = `FPC_MENU_CUR_MASK >> pos;
		return mask[0];
	endfunction

	function automatic logic fpc_mapped(input logic [11:0] addr);
		return addr == `FPC_CTRL_OFS || addr == `FPC_STATUS_OFS
			|| addr == `FPC_VSET_OFS || addr == `FPC_ISET_OFS
			|| addr == `FPC_VLIM_OFS || addr == `FPC_ILIM_OFS
			|| addr == `FPC_MENU_OFS;
	endfunction

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		logic        remote;
		logic        tick;
		logic        cur;
		logic        vuse;
		logic        iuse;
		logic        vmeas;
		logic        imeas;
		logic [16:0] res;
		logic [31:0] rd;
		remote = analog_control_port | host_remote;
		tick   = st.flash_cnt == 19'(FLASH_CYC - 1);
		cur    = fpc_cur_item(st.menu_pos);
		res    = 17'h0_0000;
		rd     = 32'h0000_0000;
		// Running output shows measurements; an encoder press flips the choice
		vmeas  = output_active ^ st.meas_v;
		imeas  = output_active ^ st.meas_i;
		case (st.panel)
			fpc_pkg::FPC_PANEL_IDLE: begin
				vuse = !remote;
				iuse = !remote;
			end
			fpc_pkg::FPC_PANEL_MENU: begin
				vuse = 1'b1;
				iuse = 1'b0;
			end
			default: begin
				vuse = !cur;
				iuse = cur;
			end
		endcase
		next_st = st;
		next_st.err_clear  = 1'b0;
		next_st.local_take = 1'b0;

		// Flash and alternation timebase
		next_st.flash_cnt = tick ? 19'h0_0000 : st.flash_cnt + 19'h0_0001;
		if (tick) begin
			next_st.flash_ph = ~st.flash_ph;
			if (st.half_cnt == 4'(`FPC_HALF_TICKS - 1)) begin
				next_st.half_cnt = 4'h0;
				next_st.alt_ph   = ~st.alt_ph;
			end else begin
				next_st.half_cnt = st.half_cnt + 4'h1;
			end
			next_st.vrng = (st.vrng != 4'h0) ? st.vrng - 4'h1 : 4'h0;
			next_st.irng = (st.irng != 4'h0) ? st.irng - 4'h1 : 4'h0;
		end
		// Activity is held until the next flash tick, so short bursts show only if they fall in the lit phase
		if (tick) begin
			next_st.rx_seen = link_rx_busy;
			next_st.tx_seen = link_tx_busy;
		end else begin
			next_st.rx_seen = st.rx_seen | link_rx_busy;
			next_st.tx_seen = st.tx_seen | link_tx_busy;
		end

		// ----------------------------------------
		// Panel state machine
		// ----------------------------------------
		case (st.panel)
			fpc_pkg::FPC_PANEL_IDLE: begin
				if (evt.press[`FPC_BTN_OUT] && !remote) begin
					next_st.gen_req = ~st.gen_req;
				end
				if (evt.press[`FPC_BTN_ABORT]) begin
					next_st.kill_en   = ~st.kill_en;
					next_st.err_clear = err_pending & err_clearable;
				end
				if (evt.press[`FPC_BTN_LOCAL]) begin
					if (remote) begin
						next_st.local_take = 1'b1;
						next_st.gen_req    = 1'b0;
					end else begin
						next_st.panel = fpc_pkg::FPC_PANEL_MENU;
					end
				end
				if (evt.press[`FPC_BTN_VENC] && !remote) begin
					next_st.meas_v = ~st.meas_v;
				end
				if (evt.press[`FPC_BTN_IENC] && !remote) begin
					next_st.meas_i = ~st.meas_i;
				end
				if (evt.step[0] && !remote) begin
					res = fpc_step(st.vset, st.vlim, evt.up[0]);
					next_st.vset = res[15:0];
					if (res[16]) begin
						next_st.vrng = `FPC_RANGE_TICKS;
					end
				end
				if (evt.step[1] && !remote) begin
					res = fpc_step(st.iset, st.ilim, evt.up[1]);
					next_st.iset = res[15:0];
					if (res[16]) begin
						next_st.irng = `FPC_RANGE_TICKS;
					end
				end
			end
			fpc_pkg::FPC_PANEL_MENU: begin
				if (evt.press[`FPC_BTN_ABORT] || remote) begin
					next_st.panel = fpc_pkg::FPC_PANEL_IDLE;
				end else if (evt.press[`FPC_BTN_VENC]) begin
					next_st.panel    = fpc_pkg::FPC_PANEL_EDIT;
					next_st.menu_val = 16'h0000;
				end else if (evt.step[0]) begin
					// Scrolling wraps at both ends, so it never reports a range end
					if (evt.up[0]) begin
						next_st.menu_pos = (st.menu_pos == `FPC_MENU_LAST) ? 4'h0 : st.menu_pos + 4'h1;
					end else begin
						next_st.menu_pos = (st.menu_pos == 4'h0) ? `FPC_MENU_LAST : st.menu_pos - 4'h1;
					end
				end
			end
			fpc_pkg::FPC_PANEL_EDIT: begin
				if (evt.press[`FPC_BTN_ABORT] || remote) begin
					next_st.panel = fpc_pkg::FPC_PANEL_MENU;
				end else if (evt.press[`FPC_BTN_VENC] || evt.press[`FPC_BTN_IENC]) begin
					next_st.panel = fpc_pkg::FPC_PANEL_MENU;
				end else if (evt.step[0] && !cur) begin
					res = fpc_step(st.menu_val, `FPC_LIM_RST, evt.up[0]);
					next_st.menu_val = res[15:0];
					if (res[16]) begin
						next_st.vrng = `FPC_RANGE_TICKS;
					end
				end else if (evt.step[1] && cur) begin
					res = fpc_step(st.menu_val, `FPC_LIM_RST, evt.up[1]);
					next_st.menu_val = res[15:0];
					if (res[16]) begin
						next_st.irng = `FPC_RANGE_TICKS;
					end
				end
			end
			default: begin
				next_st.panel = fpc_pkg::FPC_PANEL_IDLE;
			end
		endcase

		// ----------------------------------------
		// Indicators
		// ----------------------------------------
		next_st.led[0] = output_active;
		next_st.led[1] = next_st.kill_en;
		next_st.led[2] = remote;
		next_st.led[3] = err_pending;
		next_st.led[4] = st.rx_seen & st.flash_ph;
		next_st.led[5] = st.tx_seen & st.flash_ph;
		next_st.led[6] = voltage_regulation;
		next_st.led[7] = current_regulation;
		next_st.led[8] = vuse & ((st.vrng == 4'h0) | st.flash_ph);
		next_st.led[9] = iuse & ((st.irng == 4'h0) | st.flash_ph);

		// ----------------------------------------
		// Display sources
		// ----------------------------------------
		if (st.panel != fpc_pkg::FPC_PANEL_IDLE) begin
			next_st.vdisp = fpc_pkg::FPC_DISP_MENU;
			next_st.idisp = fpc_pkg::FPC_DISP_MENU;
		end else if (err_pending && st.alt_ph) begin
			next_st.vdisp = fpc_pkg::FPC_DISP_ERR;
			next_st.idisp = fpc_pkg::FPC_DISP_ERR;
		end else begin
			next_st.vdisp = vmeas ? fpc_pkg::FPC_DISP_MEAS : fpc_pkg::FPC_DISP_SET;
			if (!imeas) begin
				next_st.idisp = fpc_pkg::FPC_DISP_SET;
			end else if (st.power_sel) begin
				next_st.idisp = fpc_pkg::FPC_DISP_POWER;
			end else begin
				next_st.idisp = fpc_pkg::FPC_DISP_MEAS;
			end
		end
		next_st.vmark = (next_st.vdisp == fpc_pkg::FPC_DISP_SET) & st.flash_ph;
		next_st.imark = (next_st.idisp == fpc_pkg::FPC_DISP_SET) & st.flash_ph;

		// ----------------------------------------
		// APB slave: one wait state, write at the completing edge
		// ----------------------------------------
		if (paddr == `FPC_CTRL_OFS) begin
			rd[`FPC_CTRL_PWR] = st.power_sel;
		end else if (paddr == `FPC_STATUS_OFS) begin
			rd[6:0] = {st.panel, st.gen_req, st.kill_en, remote, err_pending, output_active};
		end else if (paddr == `FPC_VSET_OFS) begin
			rd[15:0] = st.vset;
		end else if (paddr == `FPC_ISET_OFS) begin
			rd[15:0] = st.iset;
		end else if (paddr == `FPC_VLIM_OFS) begin
			rd[15:0] = st.vlim;
		end else if (paddr == `FPC_ILIM_OFS) begin
			rd[15:0] = st.ilim;
		end else if (paddr == `FPC_MENU_OFS) begin
			rd[19:0] = {st.menu_pos, st.menu_val};
		end
		next_st.pready = psel & penable & ~st.pready;
		if (psel && penable && !st.pready) begin
			next_st.prdata  = pwrite ? 32'h0000_0000 : rd;
			next_st.pslverr = ~fpc_mapped(paddr);
		end else begin
			next_st.pslverr = 1'b0;
		end
		// Bus writes win over an encoder step in the same cycle
		if (psel && penable && st.pready && pwrite) begin
			if (paddr == `FPC_CTRL_OFS) begin
				next_st.power_sel = pwdata[`FPC_CTRL_PWR];
			end else if (paddr == `FPC_VSET_OFS) begin
				next_st.vset = pwdata[15:0];
			end else if (paddr == `FPC_ISET_OFS) begin
				next_st.iset = pwdata[15:0];
			end else if (paddr == `FPC_VLIM_OFS) begin
				next_st.vlim = pwdata[15:0];
			end else if (paddr == `FPC_ILIM_OFS) begin
				next_st.ilim = pwdata[15:0];
			end
		end

		if (srst) begin
			next_st      = '0;
			next_st.vset = `FPC_SET_RST;
			next_st.iset = `FPC_SET_RST;
			next_st.vlim = `FPC_LIM_RST;
			next_st.ilim = `FPC_LIM_RST;
		end
	end

	always_ff @(posedge clk) begin
		st <= next_st;
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign prdata             = st.prdata;
	assign pready             = st.pready;
	assign pslverr            = st.pslverr;
	assign gen_enable         = st.gen_req;
	assign fault_shutdown_en  = st.kill_en;
	assign err_clear          = st.err_clear;
	assign local_take         = st.local_take;
	assign led_output_active  = st.led[0];
	assign led_fault_shutdown = st.led[1];
	assign led_remote         = st.led[2];
	assign led_error          = st.led[3];
	assign led_rx             = st.led[4];
	assign led_tx             = st.led[5];
	assign led_vreg           = st.led[6];
	assign led_ireg           = st.led[7];
	assign led_venc           = st.led[8];
	assign led_ienc           = st.led[9];
	assign vdisp_sel          = st.vdisp;
	assign idisp_sel          = st.idisp;
	assign vdisp_s_mark       = st.vmark;
	assign idisp_s_mark       = st.imark;
endmodule // fpc_top
`default_nettype wire

//--- include/fpc_defs.svh
// Constants of the front panel indicator controller
`ifndef FPC_DEFS_SVH
`define FPC_DEFS_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define FPC_CLK_KHZ       10000
`define FPC_DEB_TIME_US   10000
`define FPC_DEB_CYC       ((`FPC_DEB_TIME_US * `FPC_CLK_KHZ) / 1000)
`define FPC_FLASH_TIME_MS 50
`define FPC_FLASH_CYC     (`FPC_FLASH_TIME_MS * `FPC_CLK_KHZ)
`define FPC_HALF_TIME_MS  500
`define FPC_HALF_TICKS    (`FPC_HALF_TIME_MS / `FPC_FLASH_TIME_MS)
`define FPC_RANGE_TICKS   4'h8

// ----------------------------------------
// Buttons and menu
// ----------------------------------------
`define FPC_BTN_OUT       0
`define FPC_BTN_ABORT     1
`define FPC_BTN_LOCAL     2
`define FPC_BTN_VENC      3
`define FPC_BTN_IENC      4
`define FPC_MENU_LAST     4'h7
`define FPC_MENU_CUR_MASK 16'h000a

// ----------------------------------------
// Register map
// ----------------------------------------
`define FPC_CTRL_OFS      12'h000
`define FPC_STATUS_OFS    12'h004
`define FPC_VSET_OFS      12'h008
`define FPC_ISET_OFS      12'h00c
`define FPC_VLIM_OFS      12'h010
`define FPC_ILIM_OFS      12'h014
`define FPC_MENU_OFS      12'h018
`define FPC_CTRL_PWR      0
`define FPC_LIM_RST       16'hffff
`define FPC_SET_RST       16'h0000
`endif

//--- include/fpc_if.sv
// Button and encoder events from the input stages to the core
`default_nettype none
interface fpc_if;
	logic [4:0] press;
	logic [1:0] step;
	logic [1:0] up;
	modport btn  (output press);
	modport enc  (output step, output up);
	modport core (input press, input step, input up);
endinterface
`default_nettype wire

//--- include/fpc_pkg.sv
// Types of the front panel indicator controller
`default_nettype none
package fpc_pkg;
	typedef enum logic [2:0] {
		FPC_DISP_SET   = 3'b000,
		FPC_DISP_MEAS  = 3'b001,
		FPC_DISP_POWER = 3'b011,
		FPC_DISP_ERR   = 3'b010,
		FPC_DISP_MENU  = 3'b110
	} fpc_disp_t;

	typedef enum logic [1:0] {
		FPC_PANEL_IDLE = 2'b00,
		FPC_PANEL_MENU = 2'b01,
		FPC_PANEL_EDIT = 2'b11
	} fpc_panel_t;

	typedef struct packed {
		logic [4:0]       s0;
		logic [4:0]       s1;
		logic [4:0]       stable;
		logic [4:0]       press;
		logic [4:0][16:0] cnt;
	} fpc_deb_t;

	typedef struct packed {
		logic [1:0] a0;
		logic [1:0] b0;
		logic [1:0] a1;
		logic [1:0] b1;
		logic [1:0] ap;
		logic [1:0] bp;
		logic [1:0] step;
		logic [1:0] up;
	} fpc_quad_t;
endpackage
`default_nettype wire

//--- verif/fpc_operator.sv
// Operator model: push buttons and rotary encoders
`default_nettype none
module fpc_operator #(
	parameter int HOLD = 14
) (
	input  wire logic       clk,
	output var  logic [4:0] btn_n,
	output var  logic [1:0] enc_a,
	output var  logic [1:0] enc_b
);
	timeunit 1ns;
	timeprecision 1ns;
	// Released buttons sit high on their pull-ups
	initial begin
		btn_n = 5'h1f;
		enc_a = 2'h0;
		enc_b = 2'h0;
	end
	// Held past the debounce window both ways
	task automatic press(input int i);
		@(posedge clk);
		btn_n[i] <= 1'b0;
		repeat (HOLD) @(posedge clk);
		btn_n[i] <= 1'b1;
		repeat (HOLD) @(posedge clk);
	endtask
	// One detent: a single edge on a or b
	task automatic step(input int e, input logic up);
		@(posedge clk);
		if ((enc_a[e] == enc_b[e]) == up) enc_b[e] <= !enc_b[e];
		else enc_a[e] <= !enc_a[e];
		repeat (10) @(posedge clk);
	endtask
endmodule // fpc_operator
`default_nettype wire

//--- verif/fpc_top_assertions.sv
// Checker bound to the front panel indicator controller top
`default_nettype none
module fpc_top_assertions (
	input wire logic               clk,
	input wire logic               srst,
	input wire logic               pready,
	input wire logic               output_active,
	input wire logic               analog_control_port,
	input wire logic               host_remote,
	input wire logic               err_pending,
	input wire logic               err_clearable,
	input wire logic               voltage_regulation,
	input wire logic               current_regulation,
	input wire logic               gen_enable,
	input wire logic               fault_shutdown_en,
	input wire logic               err_clear,
	input wire logic               local_take,
	input wire logic               led_output_active,
	input wire logic               led_fault_shutdown,
	input wire logic               led_remote,
	input wire logic               led_error,
	input wire logic               led_vreg,
	input wire logic               led_ireg,
	input wire fpc_pkg::fpc_disp_t vdisp_sel,
	input wire fpc_pkg::fpc_disp_t idisp_sel
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	// ------
	// Status lamps, one clock behind their causes except the fault lamp, which moves with fault_shutdown_en
	// ------
	property p_gen_led; 1 |=> led_output_active == $past(output_active); endproperty
	a_gen_led: assert property (p_gen_led) else $error("output lamp wrong");
	property p_remote_led; 1 |=> led_remote == $past(analog_control_port | host_remote); endproperty
	a_remote_led: assert property (p_remote_led) else $error("remote lamp wrong");
	property p_err_led; $rose(err_pending) |=> led_error; endproperty
	a_err_led: assert property (p_err_led) else $error("error lamp dark");
	property p_vreg_led; 1 |=> led_vreg == $past(voltage_regulation); endproperty
	a_vreg_led: assert property (p_vreg_led) else $error("voltage lamp wrong");
	property p_ireg_led; 1 |=> led_ireg == $past(current_regulation); endproperty
	a_ireg_led: assert property (p_ireg_led) else $error("current lamp wrong");
	property p_fault_led; $changed(fault_shutdown_en) |-> ##[0:1] led_fault_shutdown == fault_shutdown_en; endproperty
	a_fault_led: assert property (p_fault_led) else $error("fault lamp wrong");
	// ------
	// Events and displays
	// ------
	property p_take; local_take |=> !local_take && !gen_enable; endproperty
	a_take: assert property (p_take) else $error("takeover left output on");
	property p_clr; err_clear |-> err_clearable || $past(err_clearable); endproperty
	a_clr: assert property (p_clr) else $error("clear not allowed");
	property p_no_err; !err_pending [*3] |-> vdisp_sel != fpc_pkg::FPC_DISP_ERR && idisp_sel != fpc_pkg::FPC_DISP_ERR;
	endproperty
	a_no_err: assert property (p_no_err) else $error("error shown without cause");
	property p_vdisp; vdisp_sel != fpc_pkg::FPC_DISP_POWER; endproperty
	a_vdisp: assert property (p_vdisp) else $error("power on voltage display");
	property p_ready; pready |=> !pready; endproperty
	a_ready: assert property (p_ready) else $error("ready longer than one cycle");
	c_take: cover property (local_take);
	c_clr: cover property (err_clear);
	c_pwr: cover property (idisp_sel == fpc_pkg::FPC_DISP_POWER);
endmodule // fpc_top_assertions
bind fpc_top fpc_top_assertions u_chk (.*);
`default_nettype wire

//--- verif/tb.sv
// Testbench of the front panel indicator controller
`default_nettype none
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin n_errors++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, er;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
	logic output_active = 0, voltage_regulation = 0, current_regulation = 0, err_pending = 0;
	logic err_clearable = 1, analog_control_port = 0, host_remote = 0, link_rx_busy = 0, link_tx_busy = 0;
	logic gen_enable, fault_shutdown_en, err_clear, local_take, led_output_active, led_fault_shutdown;
	logic led_remote, led_error, led_rx, led_tx, led_vreg, led_ireg, led_venc, led_ienc, vdisp_s_mark, idisp_s_mark;
	fpc_pkg::fpc_disp_t vdisp_sel, idisp_sel;
	logic [4:0] bn;
	logic [1:0] ea, eb;
	int n_errors = 0, tests_run = 0, cyc = 0, n_clr = 0, n_take = 0, n;
	always #50 clk = ~clk;
	fpc_top #(.DEB_CYC(4), .FLASH_CYC(8)) uut (.*, .output_toggle_button_n(bn[0]), .abort_escape_button_n(bn[1]),
		.local_menu_button_n(bn[2]), .venc_push_n(bn[3]), .ienc_push_n(bn[4]),
		.venc_a(ea[0]), .venc_b(eb[0]), .ienc_a(ea[1]), .ienc_b(eb[1]));
	fpc_operator op (.clk(clk), .btn_n(bn), .enc_a(ea), .enc_b(eb));
	// ------
	// Plant model, pulse counters, hang guard
	// ------
	always @(posedge clk) begin
		output_active <= gen_enable;
		voltage_regulation <= gen_enable;
		link_tx_busy <= link_rx_busy;
		if (err_clear === 1'b1) n_clr <= n_clr + 1;
		if (local_take === 1'b1) n_take <= n_take + 1;
		cyc <= cyc + 1;
		if (cyc == 6000) begin
			n_errors++;
			report_and_stop();
		end
	end
	task automatic report_and_stop();
		$display("errors %0d checks %0d", n_errors, tests_run);
		if (n_errors == 0 && tests_run > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	// Waits for pready itself; only the guard ends a hang
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task automatic wt(ref logic s, input logic v);
		n = 0;
		while (s !== v && n < 200) begin
			@(posedge clk);
			n++;
		end
	endtask
	task automatic run(input logic e);
		n = 0;
		while ((vdisp_sel === fpc_pkg::FPC_DISP_ERR) === e && n < 300) begin
			@(posedge clk);
			n++;
		end
	endtask
	// ------
	// Main sequence
	// ------
	initial begin
		repeat (10) @(posedge clk);
		srst <= 0;
		repeat (2) @(posedge clk);
		`CHK("gen", 1'b0, gen_enable);
		`CHK("venc_led", 1'b1, led_venc);
		`CHK("ienc_led", 1'b1, led_ienc);
		`CHK("vdisp", fpc_pkg::FPC_DISP_SET, vdisp_sel);
		apb(0, 12'h010, 0);
		`CHK("vlim", 32'h0000_ffff, rd);
		apb(0, 12'h01c, 0);
		`CHK("unmapped", 1'b1, er);
		op.step(0, 1);
		apb(0, 12'h008, 0);
		`CHK("vset_up", 1'b1, rd != 0);
		apb(0, 12'h00c, 0);
		`CHK("iset_kept", 32'h0000_0000, rd);
		op.step(1, 1);
		apb(0, 12'h00c, 0);
		`CHK("iset_up", 1'b1, rd != 0);
		apb(1, 12'h008, 0);
		op.step(0, 0);
		wt(led_venc, 0);
		`CHK("range_flash", 1'b1, n < 200);
		apb(1, 12'h000, 1);
		op.press(0);
		`CHK("gen_on", 1'b1, gen_enable);
		`CHK("out_led", 1'b1, led_output_active);
		`CHK("vreg_led", 1'b1, led_vreg);
		`CHK("idisp", fpc_pkg::FPC_DISP_POWER, idisp_sel);
		`CHK("vdisp_meas", fpc_pkg::FPC_DISP_MEAS, vdisp_sel);
		`CHK("vmark_meas", 1'b0, vdisp_s_mark);
		`CHK("imark_pwr", 1'b0, idisp_s_mark);
		analog_control_port <= 1;
		current_regulation <= 1;
		repeat (3) @(posedge clk);
		`CHK("remote_led", 1'b1, led_remote);
		`CHK("ireg_led", 1'b1, led_ireg);
		analog_control_port <= 0;
		current_regulation <= 0;
		host_remote <= 1;
		op.press(0);
		`CHK("gen_kept", 1'b1, gen_enable);
		op.press(2);
		`CHK("take", 1, n_take);
		`CHK("gen_stop", 1'b0, gen_enable);
		host_remote <= 0;
		err_pending <= 1;
		op.press(1);
		`CHK("clr", 1, n_clr);
		`CHK("fault", 1'b1, fault_shutdown_en);
		`CHK("fault_led", 1'b1, led_fault_shutdown);
		`CHK("err_led", 1'b1, led_error);
		run(0);
		run(1);
		run(0);
		run(1);
		`CHK("err_phase", 80, n);
		err_clearable <= 0;
		op.press(1);
		`CHK("fault_off", 1'b0, fault_shutdown_en);
		`CHK("clr_refused", 1, n_clr);
		err_pending <= 0;
		op.press(2);
		`CHK("menu", fpc_pkg::FPC_DISP_MENU, vdisp_sel);
		op.step(0, 1);
		op.step(1, 1);
		apb(0, 12'h018, 0);
		`CHK("item", 4'h1, rd[19:16]);
		op.press(3);
		`CHK("ienc_use", 1'b1, led_ienc);
		`CHK("venc_unused", 1'b0, led_venc);
		op.step(1, 1);
		op.step(0, 1);
		apb(0, 12'h018, 0);
		`CHK("cur_edit", 32'h0001_0001, rd);
		op.press(1);
		op.press(1);
		`CHK("menu_left", fpc_pkg::FPC_DISP_SET, vdisp_sel);
		`CHK("fault_kept", 1'b0, fault_shutdown_en);
		wt(vdisp_s_mark, 1);
		`CHK("vmark_on", 1'b1, n < 200);
		wt(vdisp_s_mark, 0);
		`CHK("vmark_blink", 1'b1, n < 200);
		wt(idisp_s_mark, 1);
		`CHK("imark_on", 1'b1, n < 200);
		link_rx_busy <= 1;
		wt(led_rx, 1);
		`CHK("rx_led", 1'b1, n < 200);
		wt(led_tx, 1);
		`CHK("tx_led", 1'b1, n < 200);
		link_rx_busy <= 0;
		repeat (40) @(posedge clk);
		`CHK("rx_off", 1'b0, led_rx);
		`CHK("tx_off", 1'b0, led_tx);
		report_and_stop();
	end
endmodule // tb
`default_nettype wire
